// ### core/ofr_pkg.sv
package ofr_pkg;
   // ***********************************************
   // command codes and layouts
   // ***********************************************
   localparam int NUM_CH = 2;
   localparam logic [7:0] CMD_OC_ACTION = 8'h47;
   // die overtemp command code is arbitrary, no code is printed
   localparam logic [7:0] CMD_DIE_OT_ACTION = 8'hD7;
   localparam logic [7:0] OC_ACTION_RST = 8'h00;
   localparam logic [7:0] DIE_OT_ACTION_RST = 8'hC0;
   localparam int RESP_LSB = 6;
   localparam int RETRY_LSB = 3;
   localparam int DELAY_LSB = 0;
   // response codes for the overcurrent action byte
   localparam logic [1:0] RESP_LIMIT = 2'b00;
   localparam logic [1:0] RESP_BAD = 2'b01;
   localparam logic [1:0] RESP_DELAY = 2'b10;
   localparam logic [1:0] RESP_OFF = 2'b11;
   // response codes for the die overtemp action byte
   localparam logic [1:0] OT_RESP_LATCH = 2'b10;
   localparam logic [1:0] OT_RESP_HOLD = 2'b11;
   localparam logic [2:0] RETRY_NONE = 3'b000;
   // ***********************************************
   // timing
   // ***********************************************
   localparam int CLK_PERIOD_NS = 8;
   localparam int MS_NS = 1000000;
   localparam int MS_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DELAY_UNIT_MS = 16;
   localparam int DIV_W = 17;
   localparam int CNT_W = 8;
   // ***********************************************
   // channel states
   // ***********************************************
   typedef enum logic [2:0] {
      ST_OFF = 3'b000,
      ST_RUN = 3'b001,
      ST_LIMIT = 3'b010,
      ST_RETRY = 3'b011,
      ST_LATCH = 3'b100
   } ofr_state_t;
endpackage

// ### core/ofr_fault_response.sv
`timescale 1ns/100ps
`default_nettype none
module ofr_fault_response #(
   parameter int MS_CYCLES = ofr_pkg::MS_CYCLES
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic cmd_valid,
   input wire logic cmd_write,
   input wire logic [7:0] cmd_code,
   input wire logic cmd_page,
   input wire logic [7:0] cmd_wdata,
   output logic rsp_valid,
   output logic [7:0] rsp_rdata,
   input wire logic clear_faults,
   input wire logic restore_user_all,
   input wire logic maker_soft_reset_cmd,
   input wire logic [1:0] run_on,
   input wire logic [1:0] oc_detect,
   input wire logic [1:0] alert_mask_oc,
   input wire logic die_ot_fault,
   input wire logic [7:0] restart_interval_setting,
   output logic [1:0] output_enable,
   output logic [1:0] status_byte_nota,
   output logic [1:0] status_byte_iout_oc,
   output logic [1:0] status_word_iout,
   output logic [1:0] status_iout_oc_fault,
   output logic command_comm_fault,
   output logic alert_o,
   output logic alert_oe
);
   // ***********************************************
   // field decoding
   // ***********************************************
   function automatic logic [1:0] resp_of(input logic [7:0] b);
      resp_of = b[ofr_pkg::RESP_LSB +: 2];
   endfunction
   function automatic logic [2:0] retry_of(input logic [7:0] b);
      retry_of = b[ofr_pkg::RETRY_LSB +: 3];
   endfunction
   // delay in ms ticks; max 7 * 16 = 112 fits the counter
   function automatic logic [7:0] target_of(input logic [7:0] b);
      target_of = 8'(b[ofr_pkg::DELAY_LSB +: 3] * ofr_pkg::DELAY_UNIT_MS);
   endfunction
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);
   logic [7:0] action_q [ofr_pkg::NUM_CH];
   logic [7:0] die_ot_action;
   logic [1:0] oc_fault_q, run_prev_q, oc_set, oc_clr, oe_q;
   logic ms_tick_q, comm_fault_q, wr_bad, rsp_valid_q;
   logic [ofr_pkg::DIV_W-1:0] div_q;
   logic [7:0] rsp_rdata_q;
   logic alert_oe_q, alert_o_q;
   // the die overtemp byte has no storage, it is a constant
   assign die_ot_action = ofr_pkg::DIE_OT_ACTION_RST;
   // ***********************************************
   // millisecond tick
   // ***********************************************
   // one shared divider; channel delays are quantised to 1 ms
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         div_q <= '0;
         ms_tick_q <= 1'b0;
      end else if (div_q == ofr_pkg::DIV_W'(MS_CYCLES - 1)) begin
         div_q <= '0;
         ms_tick_q <= 1'b1;
      end else begin
         div_q <= ofr_pkg::DIV_W'(div_q + 1'b1);
         ms_tick_q <= 1'b0;
      end
   end
   // ***********************************************
   // command port
   // ***********************************************
   // refused writes: bad response code or the read-only byte
   assign wr_bad = cmd_valid && cmd_write &&
      ((cmd_code == ofr_pkg::CMD_OC_ACTION &&
        resp_of(cmd_wdata) == ofr_pkg::RESP_BAD) ||
       cmd_code == ofr_pkg::CMD_DIE_OT_ACTION);
   // read answer one cycle after the request; unmapped reads 0
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rsp_valid_q <= 1'b0;
         rsp_rdata_q <= 8'h00;
      end else begin
         rsp_valid_q <= cmd_valid && !cmd_write;
         if (cmd_valid && !cmd_write) begin
            if (cmd_code == ofr_pkg::CMD_OC_ACTION) begin
               rsp_rdata_q <= action_q[cmd_page];
            end else if (cmd_code == ofr_pkg::CMD_DIE_OT_ACTION) begin
               rsp_rdata_q <= die_ot_action;
            end else begin
               rsp_rdata_q <= 8'h00;
            end
         end
      end
   end
   // comm fault is sticky; a new refusal beats a clear
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         comm_fault_q <= 1'b0;
      end else begin
         comm_fault_q <= wr_bad || (comm_fault_q && !clear_faults);
      end
   end
   a_bad_code_refused: assert property (
      cmd_valid && cmd_write && cmd_code == ofr_pkg::CMD_OC_ACTION &&
      resp_of(cmd_wdata) == ofr_pkg::RESP_BAD && !restore_user_all &&
      !maker_soft_reset_cmd |=> command_comm_fault &&
      $stable(action_q[0]) && $stable(action_q[1]))
      else $error("bad response code stored or not flagged");
   a_die_ot_const: assert property (
      rsp_valid_q && $past(cmd_code) == ofr_pkg::CMD_DIE_OT_ACTION
      |-> rsp_rdata_q == 8'hC0)
      else $error("die overtemp byte misread");
   // ***********************************************
   // per-channel fault response
   // ***********************************************
   for (genvar i = 0; i < ofr_pkg::NUM_CH; i++) begin : g_ch
      ofr_pkg::ofr_state_t st_q, shut_st;
      logic [ofr_pkg::CNT_W-1:0] cnt_q;
      logic [1:0] resp, ot_resp;
      logic ot_hold;
      assign resp = resp_of(action_q[i]);
      assign ot_resp = resp_of(die_ot_action);
      assign ot_hold = die_ot_fault && ot_resp == ofr_pkg::OT_RESP_HOLD;
      // retry 000 latches off, anything else waits and restarts
      assign shut_st = (retry_of(action_q[i]) == ofr_pkg::RETRY_NONE) ?
         ofr_pkg::ST_LATCH : ofr_pkg::ST_RETRY;
      // action byte; restore and soft reset reload the default
      always_ff @(posedge clock or negedge resetn) begin
         if (!resetn) begin
            action_q[i] <= ofr_pkg::OC_ACTION_RST;
         end else if (cmd_valid && cmd_write && cmd_page == 1'(i) &&
               cmd_code == ofr_pkg::CMD_OC_ACTION &&
               resp_of(cmd_wdata) != ofr_pkg::RESP_BAD) begin
            action_q[i] <= cmd_wdata;
         end else if (restore_user_all || maker_soft_reset_cmd) begin
            action_q[i] <= ofr_pkg::OC_ACTION_RST;
         end
      end
      // response sequencer; commanded off overrides everything
      always_ff @(posedge clock or negedge resetn) begin
         if (!resetn) begin
            st_q <= ofr_pkg::ST_OFF;
            cnt_q <= '0;
         end else if (!run_on[i]) begin
            st_q <= ofr_pkg::ST_OFF;
            cnt_q <= '0;
         end else begin
            case (st_q)
               ofr_pkg::ST_OFF: begin
                  st_q <= ofr_pkg::ST_RUN;
                  cnt_q <= '0;
               end
               ofr_pkg::ST_RUN: begin
                  if (die_ot_fault && ot_resp == ofr_pkg::OT_RESP_LATCH) begin
                     st_q <= ofr_pkg::ST_LATCH;
                  end else if (oc_detect[i] &&
                        resp == ofr_pkg::RESP_DELAY) begin
                     st_q <= ofr_pkg::ST_LIMIT;
                     cnt_q <= '0;
                  end else if (oc_detect[i] && resp == ofr_pkg::RESP_OFF) begin
                     st_q <= shut_st;
                     cnt_q <= '0;
                  end
                  // response 00 stays here, limiter holds the current
               end
               ofr_pkg::ST_LIMIT: begin
                  if (die_ot_fault && ot_resp == ofr_pkg::OT_RESP_LATCH) begin
                     st_q <= ofr_pkg::ST_LATCH;
                  end else if (!oc_detect[i]) begin
                     st_q <= ofr_pkg::ST_RUN;
                  end else if (cnt_q >= target_of(action_q[i])) begin
                     st_q <= shut_st;
                     cnt_q <= '0;
                  end else if (ms_tick_q) begin
                     cnt_q <= ofr_pkg::CNT_W'(cnt_q + 1'b1);
                  end
               end
               ofr_pkg::ST_RETRY: begin
                  if (cnt_q >= restart_interval_setting) begin
                     st_q <= ofr_pkg::ST_RUN;
                     cnt_q <= '0;
                  end else if (ms_tick_q) begin
                     cnt_q <= ofr_pkg::CNT_W'(cnt_q + 1'b1);
                  end
               end
               ofr_pkg::ST_LATCH: begin
                  st_q <= ofr_pkg::ST_LATCH;
               end
               default: begin
                  st_q <= ofr_pkg::ST_OFF;
               end
            endcase
         end
      end
      // output on only while running or limiting, and not too hot
      always_ff @(posedge clock or negedge resetn) begin
         if (!resetn) begin
            oe_q[i] <= 1'b0;
         end else begin
            oe_q[i] <= (st_q == ofr_pkg::ST_RUN ||
               st_q == ofr_pkg::ST_LIMIT) && !ot_hold;
         end
      end
      // fault recorded only while run_on is high and the channel is running or limiting
      assign oc_set[i] = oc_detect[i] && run_on[i] &&
         (st_q == ofr_pkg::ST_RUN || st_q == ofr_pkg::ST_LIMIT);
      assign oc_clr[i] = clear_faults || restore_user_all ||
         maker_soft_reset_cmd || (run_on[i] && !run_prev_q[i]);
      // sticky fault bit; a new fault beats any clear
      always_ff @(posedge clock or negedge resetn) begin
         if (!resetn) begin
            oc_fault_q[i] <= 1'b0;
            run_prev_q[i] <= 1'b0;
         end else begin
            oc_fault_q[i] <= oc_set[i] || (oc_fault_q[i] && !oc_clr[i]);
            run_prev_q[i] <= run_on[i];
         end
      end
      a_oc_sets_status: assert property (
         oc_set[i] |=> status_iout_oc_fault[i] && status_byte_nota[i])
         else $error("overcurrent did not set status");
      a_fault_sticks: assert property (
         oc_fault_q[i] && !oc_clr[i] |=> oc_fault_q[i])
         else $error("fault bit dropped without a clear");
      a_brickwall_runs: assert property (
         st_q == ofr_pkg::ST_RUN && resp == ofr_pkg::RESP_LIMIT &&
         run_on[i] && !die_ot_fault |=> st_q == ofr_pkg::ST_RUN)
         else $error("brick-wall response left run");
      a_limit_restarts: assert property (
         st_q == ofr_pkg::ST_RUN && oc_detect[i] && run_on[i] &&
         !die_ot_fault && resp == ofr_pkg::RESP_DELAY
         |=> st_q == ofr_pkg::ST_LIMIT && cnt_q == '0)
         else $error("delay episode did not start from zero");
      // trip seen in run while the shutdown response is selected
      sequence s_oc_trip_off;
         st_q == ofr_pkg::ST_RUN && oc_detect[i] && run_on[i] &&
         !die_ot_fault && resp == ofr_pkg::RESP_OFF;
      endsequence
      a_immediate_off: assert property (
         s_oc_trip_off |=> ##1 !output_enable[i])
         else $error("output not disabled on shutdown response");
      a_latch_holds: assert property (
         st_q == ofr_pkg::ST_LATCH && run_on[i]
         |=> st_q == ofr_pkg::ST_LATCH && !output_enable[i])
         else $error("latched channel restarted");
      a_ot_gates_out: assert property (
         die_ot_fault |=> !output_enable[i])
         else $error("output live during die overtemp");
   end
   // ***********************************************
   // alert line and status copies
   // ***********************************************
   // open drain: drive low whenever an unmasked overcurrent fault stands
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         alert_oe_q <= 1'b0;
         alert_o_q <= 1'b0;
      end else begin
         alert_oe_q <= |(oc_fault_q & ~alert_mask_oc);
         alert_o_q <= 1'b0;
      end
   end
   a_alert_follows: assert property (
      |(oc_fault_q & ~alert_mask_oc) |=> alert_oe)
      else $error("alert not raised for unmasked fault");
   // all four status views share the one sticky bit
   assign status_byte_nota = oc_fault_q;
   assign status_byte_iout_oc = oc_fault_q;
   assign status_word_iout = oc_fault_q;
   assign status_iout_oc_fault = oc_fault_q;
   assign output_enable = oe_q;
   assign command_comm_fault = comm_fault_q;
   assign rsp_valid = rsp_valid_q;
   assign rsp_rdata = rsp_rdata_q;
   assign alert_oe = alert_oe_q;
   assign alert_o = alert_o_q;
endmodule
`default_nettype wire

// ### dv/ofr_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****
// host side of the command port
// ****
module ofr_host_model (
   input wire logic clock,
   output logic cmd_valid,
   output logic cmd_write,
   output logic [7:0] cmd_code,
   output logic cmd_page,
   output logic [7:0] cmd_wdata,
   input wire logic rsp_valid,
   input wire logic [7:0] rsp_rdata
);
   // idle values at time zero
   initial begin
      cmd_valid = 1'h0;
      cmd_write = 1'h0;
      cmd_code = 8'h00;
      cmd_page = 1'h0;
      cmd_wdata = 8'h00;
   end

   // one request per call; released qualifiers are scrambled
   task automatic req(input logic w, input logic [7:0] c,
         input logic p, input logic [7:0] d);
      @(posedge clock);
      cmd_valid <= 1'h1;
      cmd_write <= w;
      cmd_code <= c;
      cmd_page <= p;
      cmd_wdata <= d;
      @(posedge clock);
      cmd_valid <= 1'h0;
      cmd_code <= ~c;
      cmd_page <= ~p;
      cmd_wdata <= ~d;
   endtask

   // read answer is a one-cycle pulse, caught mid-cycle
   task automatic rd(input logic [7:0] c, input logic p,
         output logic [7:0] d, output logic ok);
      ok = 1'h0;
      d = 8'h00;
      req(1'h0, c, p, 8'h00);
      for (int i = 0; i < 4 && !ok; i++) begin
         @(negedge clock);
         if (rsp_valid === 1'h1) begin
            ok = 1'h1;
            d = rsp_rdata;
         end
      end
   endtask
endmodule
`default_nettype wire

// ### dv/output_overcurrent_fault_response_bench.sv
`timescale 1ns/100ps
`default_nettype none
module output_overcurrent_fault_response_bench;
   // ****
   // stimulus and observed signals
   // ****
   logic clock = 1'h0;
   logic resetn = 1'h0;
   logic clear_faults = 1'h0;
   logic restore_user_all = 1'h0;
   logic maker_soft_reset_cmd = 1'h0;
   logic [1:0] run_on = 2'h3;
   logic [1:0] oc_detect = 2'h0;
   logic [1:0] alert_mask_oc = 2'h2;
   logic die_ot_fault = 1'h0;
   logic [7:0] restart_interval_setting = 8'h03;
   logic cmd_valid, cmd_write, cmd_page, rsp_valid, ok;
   logic [7:0] cmd_code, cmd_wdata, rsp_rdata, rdat, stat;
   logic [1:0] output_enable, status_byte_nota, status_byte_iout_oc;
   logic [1:0] status_word_iout, status_iout_oc_fault;
   logic command_comm_fault, alert_o, alert_oe;
   int n_mismatch = 0;
   int num_checks = 0;
   int k;

   // 8 ns period
   always #4 clock = ~clock;
   assign stat = {status_byte_nota, status_byte_iout_oc,
      status_word_iout, status_iout_oc_fault};

   // short ms tick keeps the 16 ms delay unit at 160 cycles
   ofr_fault_response #(.MS_CYCLES(10)) dut_u (.clock, .resetn,
      .cmd_valid, .cmd_write, .cmd_code, .cmd_page, .cmd_wdata,
      .rsp_valid, .rsp_rdata, .clear_faults, .restore_user_all,
      .maker_soft_reset_cmd, .run_on, .oc_detect, .alert_mask_oc,
      .die_ot_fault, .restart_interval_setting, .output_enable,
      .status_byte_nota, .status_byte_iout_oc, .status_word_iout,
      .status_iout_oc_fault, .command_comm_fault, .alert_o,
      .alert_oe);
   ofr_host_model host_u (.clock, .cmd_valid, .cmd_write, .cmd_code,
      .cmd_page, .cmd_wdata, .rsp_valid, .rsp_rdata);

   // ****
   // helpers
   // ****
   task automatic summarize;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic nclk(input int n);
      repeat (n) @(negedge clock);
   endtask
   task automatic rchk(input logic [7:0] c, input logic p,
         input logic [7:0] exp);
      host_u.rd(c, p, rdat, ok);
      chk({7'h00, ok}, 8'h01);
      chk(rdat, exp);
   endtask
   // 0 clear faults, 1 restore, 2 soft reset
   task automatic evt(input int i);
      @(posedge clock);
      clear_faults <= (i == 0);
      restore_user_all <= (i == 1);
      maker_soft_reset_cmd <= (i == 2);
      @(posedge clock);
      clear_faults <= 1'h0;
      restore_user_all <= 1'h0;
      maker_soft_reset_cmd <= 1'h0;
   endtask
   task automatic set_oc(input logic [1:0] v);
      @(posedge clock);
      oc_detect <= v;
   endtask

   // ****
   // scenarios
   // ****
   task automatic t_regs;
      rchk(8'h47, 1'h0, 8'h00);
      rchk(8'hd7, 1'h0, 8'hc0);
      host_u.req(1'h1, 8'h47, 1'h1, 8'hcb);
      rchk(8'h47, 1'h1, 8'hcb);
      rchk(8'h47, 1'h0, 8'h00);
      host_u.req(1'h1, 8'hd7, 1'h0, 8'h00);
      nclk(2);
      chk({7'h00, command_comm_fault}, 8'h01);
      rchk(8'hd7, 1'h1, 8'hc0);
      evt(0);
      host_u.req(1'h1, 8'h47, 1'h1, 8'h7f);
      nclk(2);
      chk({7'h00, command_comm_fault}, 8'h01);
      rchk(8'h47, 1'h1, 8'hcb);
      evt(0);
      host_u.req(1'h1, 8'h10, 1'h0, 8'h55);
      nclk(2);
      chk({7'h00, command_comm_fault}, 8'h00);
      rchk(8'h10, 1'h0, 8'h00);
      // restore reloads both bytes so later scenarios start from 00
      evt(1);
      rchk(8'h47, 1'h1, 8'h00);
   endtask
   // shared die overtemp trips both channels only while hot
   task automatic t_ot;
      @(posedge clock);
      die_ot_fault <= 1'h1;
      nclk(3);
      chk({6'h00, output_enable}, 8'h00);
      @(posedge clock);
      die_ot_fault <= 1'h0;
      nclk(3);
      chk({6'h00, output_enable}, 8'h03);
   endtask
   task automatic t_mask;
      set_oc(2'h2);
      nclk(3);
      chk(stat, 8'haa);
      chk({7'h00, alert_oe}, 8'h00);
      set_oc(2'h3);
      nclk(3);
      chk(stat, 8'hff);
      chk({7'h00, alert_oe}, 8'h01);
      chk({7'h00, alert_o}, 8'h00);
      nclk(20);
      chk({6'h00, output_enable}, 8'h03);
      set_oc(2'h0);
      evt(0);
      nclk(1);
      chk(stat, 8'h00);
   endtask
   // delay bits set but must not matter for immediate shutdown
   task automatic t_off;
      host_u.req(1'h1, 8'h47, 1'h0, 8'hc7);
      set_oc(2'h1);
      nclk(3);
      chk({6'h00, output_enable}, 8'h02);
      chk(stat, 8'h55);
      set_oc(2'h0);
      nclk(20);
      chk({6'h00, output_enable}, 8'h02);
      @(posedge clock);
      run_on <= 2'h2;
      nclk(3);
      @(posedge clock);
      run_on <= 2'h3;
      nclk(3);
      chk(stat, 8'h00);
      chk({6'h00, output_enable}, 8'h03);
   endtask
   // delay 1 unit is 160 cycles, up to one tick short
   task automatic t_delay;
      host_u.req(1'h1, 8'h47, 1'h0, 8'h91);
      set_oc(2'h1);
      nclk(100);
      set_oc(2'h0);
      nclk(3);
      chk({6'h00, output_enable}, 8'h03);
      set_oc(2'h1);
      nclk(140);
      chk({6'h00, output_enable}, 8'h03);
      k = 0;
      while (output_enable[0] === 1'h1 && k < 40) begin
         nclk(1);
         k++;
      end
      chk({7'h00, k < 40}, 8'h01);
      set_oc(2'h0);
      k = 0;
      while (output_enable[0] !== 1'h1 && k < 60) begin
         nclk(1);
         k++;
      end
      chk({7'h00, k >= 20 && k < 50}, 8'h01);
      evt(0);
   endtask
   task automatic t_clear;
      for (int i = 0; i < 3; i++) begin
         host_u.req(1'h1, 8'h47, 1'h0, 8'h38);
         set_oc(2'h1);
         nclk(2);
         chk(stat, 8'h55);
         set_oc(2'h0);
         evt(i);
         nclk(1);
         chk(stat, 8'h00);
         rchk(8'h47, 1'h0, (i == 0) ? 8'h38 : 8'h00);
      end
   endtask

   // main sequence after 16 cycles of reset
   initial begin
      repeat (16) @(posedge clock);
      resetn <= 1'h1;
      repeat (4) @(posedge clock);
      t_regs;
      t_ot;
      t_mask;
      t_off;
      t_delay;
      t_clear;
      summarize;
   end
   // hang guard
   initial begin
      repeat (20000) @(posedge clock);
      n_mismatch++;
      summarize;
   end
endmodule
`default_nettype wire
